// File: smbc_pkg.sv
// Purpose: constants and types shared by the serial engine mode and baud core
// Assumes: single clock domain, core clock 40 MHz
// Notes: shared offsets, reset values and counts live here; the core keeps its zero resets and 8/3-rate vote positions
package smbc_pkg;

  // ****************************************
  // operating modes
  // ****************************************
  typedef enum logic [2:0] {
    SMBC_UART_EXT = 3'h0, // async/sync serial, external clock
    SMBC_UART_INT = 3'h1, // async/sync serial, internal clock
    SMBC_SPI_SLV = 3'h2, // spi slave
    SMBC_SPI_MST = 3'h3, // spi master
    SMBC_TW_SLV = 3'h4, // two-wire slave
    SMBC_TW_MST = 3'h5 // two-wire master
  } smbc_mode_e;

  // ****************************************
  // reset values and counts
  // ****************************************
  localparam logic [2:0] SMBC_MODE_RST = 3'h0; // mode after reset
  localparam logic [1:0] SMBC_FORM_PARITY = 2'h1; // frame format with parity
  localparam int SMBC_SMART_SPACING = 6; // bus cycles from SDA change to SCL rise
  localparam int SMBC_HS_FIXED = 2; // fixed term of the high-speed SCL period
  localparam logic [3:0] SMBC_TX_DIV = 4'hF; // async transmit divide-by-16, minus one
  localparam logic [1:0] SMBC_SPB16 = 2'h0; // 16 samples per bit
  localparam logic [1:0] SMBC_SPB8 = 2'h1; // 8 samples per bit
  localparam logic [1:0] SMBC_SPB3 = 2'h2; // 3 samples per bit
  localparam logic [3:0] SMBC_DMIN = 4'h5; // shortest character plus parity
  localparam logic [3:0] SMBC_DMAX = 4'hA; // longest character plus parity
  localparam logic [3:0] SMBC_DLEN_RST = 4'h8; // character length after reset
  localparam logic [3:0] SMBC_VF_RST = 4'h7; // first vote sample after reset
  localparam logic [3:0] SMBC_VM_RST = 4'h8; // middle vote sample after reset

endpackage

// File: smbc_hs_scl.sv
// Purpose: free-running high-speed two-wire SCL generator
// Assumes: run is held while the master owns the bus
// Notes: no synchronisation with other masters, by design
`timescale 1ns/1ps
`default_nettype none
module smbc_hs_scl
  import smbc_pkg::*;
#(
  parameter int DW = 8
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic run,
  input wire logic [DW-1:0] hs_div,
  input wire logic [DW-1:0] hs_low_div,
  output logic scl
);
  // refuse divider widths the phase counter cannot serve, at elaboration
  if (DW < 1 || DW > 16) $error("smbc_hs_scl: DW out of range");

  logic [DW:0] cnt_r, cnt_nxt; // cycles left in the current phase
  logic scl_r, scl_nxt; // scl level, released high when idle
  logic [DW:0] high_len; // cycles in high phase
  logic [DW:0] low_len; // cycles in low phase

  // ****************************************
  // phase lengths
  // ****************************************
  // split of 2+2*div or 2+div+low into two phases, each at least one cycle
  always_comb begin
    high_len = {1'b0, hs_div} + (DW+1)'(SMBC_HS_FIXED / 2);
    if (hs_low_div == '0) begin
      low_len = high_len;
    end else begin
      low_len = {1'b0, hs_low_div} + (DW+1)'(SMBC_HS_FIXED / 2);
    end
  end

  // next state: count only on core clock, never look at the wire
  always_comb begin
    cnt_nxt = cnt_r;
    scl_nxt = scl_r;
    if (!run) begin
      cnt_nxt = '0;
      scl_nxt = 1'b1;
    end else if (cnt_r <= (DW+1)'(1)) begin
      scl_nxt = ~scl_r;
      cnt_nxt = scl_r ? low_len : high_len;
    end else begin
      cnt_nxt = cnt_r - (DW+1)'(1);
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cnt_r <= '0;
      scl_r <= 1'b1;
    end else begin
      cnt_r <= cnt_nxt;
      scl_r <= scl_nxt;
    end
  end

  assign scl = scl_r;

  // a low phase that runs out must hand over to a full high phase
  sequence s_low_ends;
    run && !scl_r && cnt_r <= (DW+1)'(1);
  endsequence
  // dividers held, so the loaded length is the programmed one
  sequence s_div_held;
    run && $stable(hs_div) && $stable(hs_low_div);
  endsequence
  a_hs_high_len: assert property (@(posedge clk) disable iff (reset)
    s_low_ends ##1 s_div_held |-> scl_r && cnt_r == high_len) else $error("hs high phase broken");
  a_hs_idle_high: assert property (@(posedge clk) disable iff (reset)
    !run |=> scl_r) else $error("hs scl not released when idle");
endmodule
`default_nettype wire

// File: smbc_core.sv
// Purpose: mode decode, enable, soft reset, baud taps and receiver sample points
// Assumes: control bits are plain ports sampled on clk; writes are one-cycle strobes
// Notes: protocol shifters sit outside and use the ticks and positions below
`timescale 1ns/1ps
`default_nettype none
module smbc_core
  import smbc_pkg::*;
#(
  parameter int BAUD_W = 16, // baud register width
  parameter int HS_W = 8 // high-speed divider field width
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic ctrl_wr, // one-cycle write strobe for control fields
  input wire logic enable_bit, // written enable value
  input wire logic soft_reset_bit, // written soft reset value
  input wire logic [2:0] operating_mode_field,
  input wire logic [1:0] frame_format_field,
  input wire logic parity_odd, // parity sense when parity is on
  input wire logic [1:0] samples_sel, // 16/8/3 samples per bit
  input wire logic [1:0] sample_adjust_field,
  input wire logic [3:0] char_bits, // character plus parity length
  input wire logic smart_mode,
  input wire logic baud_wr, // one-cycle strobe for the baud fields
  input wire logic [BAUD_W-1:0] baud_value,
  input wire logic [HS_W-1:0] high_speed_divider,
  input wire logic [HS_W-1:0] high_speed_low_divider,
  input wire logic hs_run, // high-speed master transfer in progress
  input wire logic data_wr, // software wrote the data register
  input wire logic sda_changed, // sda output just changed
  input wire logic [7:0] debug_control_in, // debug control register value
  input wire logic debug_wr,
  output logic engine_active,
  output logic mode_reserved,
  output logic [2:0] mode_out,
  output logic rx_tick, // receiver tick, baud /1
  output logic tx_tick, // transmitter tick
  output logic sync_clk, // synchronous serial clock, baud /2
  output logic [3:0] vote_first,
  output logic [3:0] vote_middle,
  output logic parity_en,
  output logic parity_odd_out,
  output logic length_ok,
  output logic scl_rise_ok, // smart-mode start-up spacing met
  output logic hs_scl,
  output logic [7:0] debug_control
);
  if (BAUD_W < 2 || BAUD_W > 24) $error("smbc_core: BAUD_W out of range");
  // ****************************************
  // control registers
  // ****************************************
  logic en_r, en_nxt; // engine enable
  logic [2:0] mode_r, mode_nxt;
  logic [1:0] form_r, form_nxt;
  logic odd_r, odd_nxt;
  logic [1:0] spb_r, spb_nxt;
  logic [1:0] sampa_r, sampa_nxt;
  logic [3:0] dlen_r, dlen_nxt;
  logic smart_r, smart_nxt;
  logic [BAUD_W-1:0] baud_r, baud_nxt;
  logic [HS_W-1:0] hsd_r, hsd_nxt;
  logic [HS_W-1:0] hsl_r, hsl_nxt;
  logic [7:0] dbg_r, dbg_nxt; // survives soft reset
  logic resv_r, resv_nxt; // reserved mode code, kept in a flop for the output
  // next values: soft reset restores everything but debug control
  always_comb begin
    en_nxt = en_r;
    mode_nxt = mode_r;
    form_nxt = form_r;
    odd_nxt = odd_r;
    spb_nxt = spb_r;
    sampa_nxt = sampa_r;
    dlen_nxt = dlen_r;
    smart_nxt = smart_r;
    baud_nxt = baud_r;
    hsd_nxt = hsd_r;
    hsl_nxt = hsl_r;
    dbg_nxt = debug_wr ? debug_control_in : dbg_r;
    if (ctrl_wr && soft_reset_bit) begin
      en_nxt = 1'b0;
      mode_nxt = SMBC_MODE_RST;
      form_nxt = '0;
      odd_nxt = 1'b0;
      spb_nxt = SMBC_SPB16;
      sampa_nxt = '0;
      dlen_nxt = SMBC_DLEN_RST;
      smart_nxt = 1'b0;
      baud_nxt = '0;
      hsd_nxt = '0;
      hsl_nxt = '0;
    end else begin
      if (ctrl_wr) begin
        en_nxt = enable_bit;
        mode_nxt = operating_mode_field;
        form_nxt = frame_format_field;
        odd_nxt = parity_odd;
        spb_nxt = samples_sel;
        sampa_nxt = sample_adjust_field;
        dlen_nxt = char_bits;
        smart_nxt = smart_mode;
      end
      if (baud_wr) begin
        baud_nxt = baud_value;
        hsd_nxt = high_speed_divider;
        hsl_nxt = high_speed_low_divider;
      end
    end
    resv_nxt = (mode_nxt > 3'(SMBC_TW_MST));
  end
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      en_r <= 1'b0;
      resv_r <= 1'b0;
      mode_r <= SMBC_MODE_RST;
      form_r <= '0;
      odd_r <= 1'b0;
      spb_r <= SMBC_SPB16;
      sampa_r <= '0;
      dlen_r <= SMBC_DLEN_RST;
      smart_r <= 1'b0;
      baud_r <= '0;
      hsd_r <= '0;
      hsl_r <= '0;
      dbg_r <= '0;
    end else begin
      en_r <= en_nxt;
      resv_r <= resv_nxt;
      mode_r <= mode_nxt;
      form_r <= form_nxt;
      odd_r <= odd_nxt;
      spb_r <= spb_nxt;
      sampa_r <= sampa_nxt;
      dlen_r <= dlen_nxt;
      smart_r <= smart_nxt;
      baud_r <= baud_nxt;
      hsd_r <= hsd_nxt;
      hsl_r <= hsl_nxt;
      dbg_r <= dbg_nxt;
    end
  end
  // ****************************************
  // baud generator and taps
  // ****************************************
  logic run; // engine allowed to clock the link
  logic [BAUD_W-1:0] bcnt_r, bcnt_nxt; // baud divider
  logic [3:0] t16_r, t16_nxt; // divide-by-16 tap counter
  logic sclk_r, sclk_nxt; // divide-by-2 tap
  logic rx_r, rx_nxt;
  logic tx_r, tx_nxt;
  logic bpulse; // baud generator output, one cycle every baud+1
  logic async_mode; // serial modes use /16 and /1, others /2
  assign run = en_r && !resv_r;
  assign bpulse = run && (bcnt_r == '0);
  assign async_mode = (mode_r == 3'(SMBC_UART_EXT)) || (mode_r == 3'(SMBC_UART_INT));
  // next values of the taps; the choice is made from the mode alone
  always_comb begin
    bcnt_nxt = bcnt_r;
    t16_nxt = t16_r;
    sclk_nxt = sclk_r;
    rx_nxt = 1'b0;
    tx_nxt = 1'b0;
    if (!run) begin
      bcnt_nxt = baud_r;
      t16_nxt = '0;
      sclk_nxt = 1'b0;
    end else begin
      bcnt_nxt = (bcnt_r == '0) ? baud_r : bcnt_r - BAUD_W'(1);
      if (bpulse) begin
        if (async_mode) begin
          rx_nxt = 1'b1;
          t16_nxt = t16_r + 4'h1;
          tx_nxt = (t16_r == SMBC_TX_DIV);
        end else begin
          sclk_nxt = ~sclk_r;
        end
      end
    end
  end
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      bcnt_r <= '0;
      t16_r <= '0;
      sclk_r <= 1'b0;
      rx_r <= 1'b0;
      tx_r <= 1'b0;
    end else begin
      bcnt_r <= bcnt_nxt;
      t16_r <= t16_nxt;
      sclk_r <= sclk_nxt;
      rx_r <= rx_nxt;
      tx_r <= tx_nxt;
    end
  end
  // ****************************************
  // sample points, parity, smart spacing
  // ****************************************
  logic [3:0] vf_r, vf_nxt;
  logic [3:0] vm_r, vm_nxt;
  logic [2:0] gap_r, gap_nxt; // cycles since sda change or smart-mode data write, saturating
  logic ok_r, ok_nxt;
  logic len_r, len_nxt;
  logic par_r, par_nxt;
  // vote positions from samples per bit, shifted by the adjust field
  always_comb begin
    unique case (spb_r)
      SMBC_SPB8: begin
        vf_nxt = 4'h3;
        vm_nxt = 4'h4;
      end
      SMBC_SPB3: begin
        vf_nxt = 4'h2;
        vm_nxt = 4'h2;
      end
      default: begin
        vf_nxt = 4'h7;
        vm_nxt = 4'h8;
      end
    endcase
    vf_nxt = vf_nxt + {2'b00, sampa_r};
    vm_nxt = vm_nxt + {2'b00, sampa_r};
    len_nxt = (dlen_r >= SMBC_DMIN) && (dlen_r <= SMBC_DMAX);
    par_nxt = (form_r == SMBC_FORM_PARITY);
    gap_nxt = gap_r;
    if (sda_changed || (data_wr && smart_r)) begin
      gap_nxt = '0;
    end else if (gap_r != 3'(SMBC_SMART_SPACING)) begin
      gap_nxt = gap_r + 3'h1;
    end
    // without smart mode software owns the timing
    ok_nxt = !smart_r || (gap_nxt == 3'(SMBC_SMART_SPACING));
  end
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      vf_r <= SMBC_VF_RST;
      vm_r <= SMBC_VM_RST;
      gap_r <= 3'(SMBC_SMART_SPACING);
      ok_r <= 1'b1;
      len_r <= 1'b1;
      par_r <= 1'b0;
    end else begin
      vf_r <= vf_nxt;
      vm_r <= vm_nxt;
      gap_r <= gap_nxt;
      ok_r <= ok_nxt;
      len_r <= len_nxt;
      par_r <= par_nxt;
    end
  end
  // high-speed scl only when master mode runs
  smbc_hs_scl #(.DW(HS_W)) u_hs (
    .clk(clk),
    .reset(reset),
    .run(run && hs_run && (mode_r == 3'(SMBC_TW_MST))),
    .hs_div(hsd_r),
    .hs_low_div(hsl_r),
    .scl(hs_scl)
  );
  assign engine_active = en_r;
  assign mode_reserved = resv_r;
  assign mode_out = mode_r;
  assign rx_tick = rx_r;
  assign tx_tick = tx_r;
  assign sync_clk = sclk_r;
  assign vote_first = vf_r;
  assign vote_middle = vm_r;
  assign parity_en = par_r;
  assign parity_odd_out = odd_r;
  assign length_ok = len_r;
  assign scl_rise_ok = ok_r;
  assign debug_control = dbg_r;
  // ****************************************
  // checks
  // ****************************************
  sequence s_swrst;
    ctrl_wr && soft_reset_bit;
  endsequence
  a_swrst_disable: assert property (@(posedge clk) disable iff (reset)
    s_swrst |=> !en_r && mode_r == SMBC_MODE_RST) else $error("soft reset left engine on");
  a_swrst_dbg: assert property (@(posedge clk) disable iff (reset)
    (s_swrst and !debug_wr) |=> $stable(dbg_r)) else $error("soft reset hit debug");
  a_enable_wr: assert property (@(posedge clk) disable iff (reset)
    ctrl_wr && !soft_reset_bit |=> en_r == $past(enable_bit)) else $error("enable write lost");
  a_resv_idle: assert property (@(posedge clk) disable iff (reset)
    resv_r |=> !rx_r && !tx_r && !sclk_r) else $error("activity in reserved mode");
  a_sync_no_rx: assert property (@(posedge clk) disable iff (reset)
    !async_mode |=> !rx_r && !tx_r) else $error("async tick in sync mode");
  a_rx_every: assert property (@(posedge clk) disable iff (reset)
    bpulse && async_mode |=> rx_r) else $error("receive tick missing");
  a_tx_div16: assert property (@(posedge clk) disable iff (reset)
    tx_r |-> $past(t16_r) == SMBC_TX_DIV) else $error("transmit tick not /16");
  a_vote16: assert property (@(posedge clk) disable iff (reset)
    spb_r == SMBC_SPB16 && sampa_r == '0 ##1 $stable(spb_r) && $stable(sampa_r)
    |-> vf_r == 4'h7 && vm_r == 4'h8) else $error("vote position wrong");
  a_parity_on: assert property (@(posedge clk) disable iff (reset)
    form_r == SMBC_FORM_PARITY |=> par_r) else $error("parity not enabled");
  a_smart_gap: assert property (@(posedge clk) disable iff (reset)
    smart_r && sda_changed |=> !ok_r [*6]) else $error("scl allowed too early");
endmodule
`default_nettype wire

// File: smbc_link_peer.sv
// Purpose: far-side two-wire peer that times the high-speed scl phases
// Assumes: scl sampled on the core clock, idle high
// Notes: the peer never stretches scl, so phase lengths are the master's own
`timescale 1ns/1ps
`default_nettype none
module smbc_link_peer (
  input wire logic clk,
  input wire logic reset,
  input wire logic scl,
  output logic [15:0] hi_len,
  output logic [15:0] lo_len
);
  logic [15:0] run_r, run_nxt; // samples in the current phase
  logic [15:0] hi_r, hi_nxt; // last complete high phase
  logic [15:0] lo_r, lo_nxt; // last complete low phase
  logic scl_r; // level seen at the previous edge
  // close a phase on every level change; no hold-off is ever applied
  always_comb begin
    run_nxt = run_r + 16'h0001;
    hi_nxt = hi_r;
    lo_nxt = lo_r;
    if (scl !== scl_r) begin
      run_nxt = 16'h0001;
      if (scl_r) begin
        hi_nxt = run_r;
      end else begin
        lo_nxt = run_r;
      end
    end
  end
  // register only
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      run_r <= 16'h0000;
      hi_r <= 16'h0000;
      lo_r <= 16'h0000;
      scl_r <= 1'b1;
    end else begin
      run_r <= run_nxt;
      hi_r <= hi_nxt;
      lo_r <= lo_nxt;
      scl_r <= scl;
    end
  end
  assign hi_len = hi_r;
  assign lo_len = lo_r;
endmodule
`default_nettype wire

// File: smbc_core_tb.sv
// Purpose: self-checking bench for the mode and baud core
// Assumes: 40 MHz clock, reset held 10 cycles
// Notes: tick gaps are measured at the falling edge, away from updates
`timescale 1ns/1ps
`default_nettype none
module smbc_core_tb;
  import smbc_pkg::*;
  logic clk, reset, ctrl_wr, enable_bit, soft_reset_bit, parity_odd, smart_mode;
  logic baud_wr, hs_run, data_wr, sda_changed, debug_wr;
  logic engine_active, mode_reserved, rx_tick, tx_tick, sync_clk, parity_en;
  logic parity_odd_out, length_ok, scl_rise_ok, hs_scl, sc_q;
  logic [2:0] operating_mode_field, mode_out;
  logic [1:0] frame_format_field, samples_sel, sample_adjust_field;
  logic [3:0] char_bits, vote_first, vote_middle;
  logic [15:0] baud_value, hi_len, lo_len;
  logic [7:0] high_speed_divider, high_speed_low_divider, debug_control_in, debug_control;
  logic [31:0] seed;
  int fail_count, num_checks, cyc, rx_last, rx_gap, tx_last, tx_gap, sc_last, sc_gap, nt;
  int n, e;
  int vf[3] = '{7, 3, 2}; // first vote sample per rate
  int vm[3] = '{8, 4, 2}; // middle vote sample per rate
  smbc_core #(.BAUD_W(16), .HS_W(8)) dut_u (.clk, .reset, .ctrl_wr, .enable_bit,
    .soft_reset_bit, .operating_mode_field, .frame_format_field, .parity_odd,
    .samples_sel, .sample_adjust_field, .char_bits, .smart_mode, .baud_wr, .baud_value,
    .high_speed_divider, .high_speed_low_divider, .hs_run, .data_wr, .sda_changed,
    .debug_control_in, .debug_wr, .engine_active, .mode_reserved, .mode_out, .rx_tick,
    .tx_tick, .sync_clk, .vote_first, .vote_middle, .parity_en, .parity_odd_out,
    .length_ok, .scl_rise_ok, .hs_scl, .debug_control);
  smbc_link_peer peer_u (.clk, .reset, .scl(hs_scl), .hi_len, .lo_len);
  // ****************************************
  // clock, monitor, helpers
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // gaps between ticks and sync clock edges, the bench's timing model
  always @(negedge clk) begin
    cyc++;
    if (rx_tick === 1'b1) begin
      rx_gap = cyc - rx_last;
      rx_last = cyc;
      nt++;
    end
    if (tx_tick === 1'b1) begin
      tx_gap = cyc - tx_last;
      tx_last = cyc;
      nt++;
    end
    if (sync_clk !== sc_q) begin
      sc_gap = cyc - sc_last;
      sc_last = cyc;
    end
    sc_q = sync_clk;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %0h seen %0h", nm, exp, got);
    end
  endtask
  // control write; other fields are already set by the caller
  task automatic cw(input logic [2:0] m, input logic en, input logic sr);
    @(posedge clk);
    operating_mode_field <= m;
    enable_bit <= en;
    soft_reset_bit <= sr;
    ctrl_wr <= 1'b1;
    @(posedge clk);
    ctrl_wr <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  task automatic bw(input logic [15:0] b, input logic [7:0] d, input logic [7:0] l);
    @(posedge clk);
    baud_value <= b;
    high_speed_divider <= d;
    high_speed_low_divider <= l;
    baud_wr <= 1'b1;
    @(posedge clk);
    baud_wr <= 1'b0;
  endtask
  task automatic report_and_stop;
    if (fail_count == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // a hang counts as a mismatch
  initial begin
    #500000;
    fail_count++;
    report_and_stop();
  end
  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    {ctrl_wr, enable_bit, soft_reset_bit, parity_odd, smart_mode} = '0;
    {baud_wr, hs_run, data_wr, sda_changed, debug_wr} = '0;
    {operating_mode_field, frame_format_field, samples_sel, sample_adjust_field} = '0;
    char_bits = 4'h8;
    baud_value = 16'h0001;
    {high_speed_divider, high_speed_low_divider, debug_control_in} = '0;
    seed = 32'hBA14;
    reset = 1'b1;
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    chk("idle active", 16'h0, engine_active);
    chk("idle scl", 16'h1, hs_scl);
    chk("idle vote", 16'h78, {vote_first, vote_middle});
    // every mode code, reserved ones stay silent
    bw(16'h0000, 8'h01, 8'h00);
    hs_run <= 1'b1;
    for (int m = 0; m < 8; m++) begin
      cw(m[2:0], 1'b1, 1'b0);
      n = nt;
      repeat (40) @(posedge clk);
      chk("reserved flag", 16'(m > 5), mode_reserved);
      if (m < 6) chk("mode", 16'(m), mode_out);
      else chk("quiet ticks", 16'(n), 16'(nt));
      if (m > 5) chk("quiet link", 16'h1, {sync_clk, hs_scl});
    end
    hs_run <= 1'b0;
    // enable on and off
    cw(3'h1, 1'b1, 1'b0);
    chk("enable on", 16'h1, engine_active);
    cw(3'h1, 1'b0, 1'b0);
    chk("enable off", 16'h0, engine_active);
    // async and sync taps for two baud settings
    for (int b = 1; b < 3; b++) begin
      bw(16'(b), 8'h01, 8'h00);
      cw(3'h1, 1'b1, 1'b0);
      repeat (120) @(posedge clk);
      chk("rx gap", 16'(b + 1), 16'(rx_gap));
      chk("tx gap", 16'(16 * (b + 1)), 16'(tx_gap));
      cw(3'h3, 1'b1, 1'b0);
      repeat (20) @(posedge clk);
      chk("sync half", 16'(b + 1), 16'(sc_gap));
    end
    // vote positions, parity and frame length
    for (int s = 0; s < 3; s++) begin
      for (int a = 0; a < 2; a++) begin
        seed = xs(seed);
        samples_sel <= s[1:0];
        sample_adjust_field <= a[1:0];
        frame_format_field <= seed[1:0];
        parity_odd <= seed[2];
        char_bits <= {1'b0, seed[5:3]} + 4'h4;
        cw(3'h1, 1'b1, 1'b0);
        chk("vote first", 16'(vf[s] + a), vote_first);
        chk("vote mid", 16'(vm[s] + a), vote_middle);
        chk("parity on", 16'(seed[1:0] == 2'h1), parity_en);
        if (seed[1:0] == 2'h1) chk("parity odd", 16'(seed[2]), parity_odd_out);
        e = seed[5:3] + 4;
        chk("length", 16'(e >= 5 && e <= 10), length_ok);
      end
    end
    // soft reset keeps debug control only
    @(posedge clk);
    debug_control_in <= 8'hA5;
    debug_wr <= 1'b1;
    @(posedge clk);
    debug_wr <= 1'b0;
    cw(3'h3, 1'b1, 1'b1);
    chk("srst active", 16'h0, {engine_active, mode_out});
    chk("srst vote", 16'h78, {vote_first, vote_middle});
    chk("srst debug", 16'hA5, debug_control);
    chk("srst fields", 16'h1, {parity_en, parity_odd_out, length_ok});
    // smart start-up spacing after data and sda changes
    smart_mode <= 1'b1;
    cw(3'h5, 1'b1, 1'b0);
    for (int k = 0; k < 3; k++) begin
      if (k == 2) smart_mode <= 1'b0;
      if (k == 2) cw(3'h5, 1'b1, 1'b0);
      @(posedge clk);
      if (k == 1) sda_changed <= 1'b1;
      else data_wr <= 1'b1;
      @(posedge clk);
      {sda_changed, data_wr} <= 2'b00;
      n = 0;
      repeat (20) @(negedge clk) n += (scl_rise_ok === 1'b0);
      e = SMBC_SMART_SPACING;
      if (k < 2) chk("smart gap", 16'h1, 16'(n >= e && n < e + 3));
      else chk("smart off", 16'h0, 16'(n));
    end
    // high-speed scl, random dividers, at least one nonzero
    hs_run <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      seed = xs(seed);
      n = (i < 3) ? int'(seed[3:0] | 4'h1) : 0;
      e = i[0] ? int'(seed[7:4] | {3'h0, i == 3}) : 0;
      bw(16'h0001, 8'(n), 8'(e));
      repeat (120) @(posedge clk);
      // a zero low divider makes the high divider set both phases
      if (e == 0) e = n;
      chk("scl high", 16'(n + 1), hi_len);
      chk("scl low", 16'(e + 1), lo_len);
      chk("scl period", 16'(SMBC_HS_FIXED + n + e), hi_len + lo_len);
    end
    report_and_stop();
  end
endmodule
`default_nettype wire
